// ### rtl/sscf_pkg.sv
package sscf_pkg;
	// ==========================================
	// status register field positions
	localparam int unsigned STAT_ERR_BIT  = 7;
	localparam int unsigned STAT_LOW_BIT  = 6;
	localparam int unsigned STAT_IDLE_BIT = 5;
	localparam int unsigned STAT_CONV_BIT = 4;
	localparam logic [7:0]  STAT_RESET    = 8'h30;
	// ==========================================
	// address register
	localparam logic [7:0]  ADDR_FACTORY  = 8'hA0;
	localparam int unsigned ADDR_LSB      = 1;
	// ==========================================
	// command codes
	localparam logic [7:0]  CMD_RD_STATUS = 8'h0A;
	localparam logic [7:0]  CMD_RD_ADDR   = 8'h06;
	localparam logic [7:0]  CMD_WR_ADDR   = 8'h07;
	localparam logic [7:0]  CMD_RESET     = 8'h0C;
	localparam logic [7:0]  CMD_RESTORE   = 8'h0D;
	// ==========================================
	// timing
	localparam int unsigned CLK_MHZ       = 125;
	localparam int unsigned IDLE_LIMIT_MS = 10;
	localparam int unsigned IDLE_LIMIT_CYC = IDLE_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned WRITE_BUSY_CYC = 4;
	localparam int unsigned SWRST_CYC      = 2;

	// decoded command from the framing logic
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] data;
		logic       bad;
	} sscf_cmd_t;

	// one response byte towards the framing logic
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} sscf_rsp_t;
endpackage

// ### rtl/sscf_idle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sscf_idle_timer #(
	parameter int unsigned LIMIT = 1250000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// activity
	input  wire logic busy,
	input  wire logic activity,
	// result
	output logic      expired
);
	logic [31:0] count_ff;

	// ==========================================
	// idle counter: restarts on each link edge, held at zero outside transactions
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_ff <= 32'h0;
			expired  <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (!busy || activity) begin
				count_ff <= 32'h0;
			end else if (count_ff == LIMIT - 1) begin
				count_ff <= 32'h0;
				expired  <= 1'b1; // one-cycle pulse, repeated every LIMIT cycles while the stall lasts
			end else begin
				count_ff <= count_ff + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/sscf_status_addr.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: error flag sets on bad command or time-out, clears after status read.
// RULE2: low-voltage flag sets while supply monitor reports low, clears after read.
// RULE3: setup flag drops to busy when a write command begins executing.
// RULE4: setup flag returns to standby by itself when the write finishes.
// RULE5: conversion flag sets on power-on, software reset and wake-up.
// RULE6: conversion flag clears when new measurement data is ready.
// RULE7: target address for matching comes from address register bits 7..1.
// RULE8: host writes zero into address register bit 0.
// RULE9: restore command reloads factory address, then software reset.
// RULE10: in serial-bus mode the device only answers, never initiates.
// RULE11: error flag sets when either link idles mid-transaction over 10 ms.
// RULE12: status read answers with exactly one byte, the status contents.
// RULE13: restore uses code 0x0D and gets no response.
// RULE14: status bits 3..0 read zero; host cannot alter status bits.
// RULE15: error and low flags clear only after the status byte is sent.
module sscf_status_addr #(
	parameter int unsigned IDLE_LIMIT = sscf_pkg::IDLE_LIMIT_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// decoded commands and response handshake
	input  wire sscf_pkg::sscf_cmd_t cmd,
	input  wire logic              rsp_sent,
	output var sscf_pkg::sscf_rsp_t rsp,
	// link activity for time-out
	input  wire logic              uart_busy,
	input  wire logic              uart_edge,
	input  wire logic              i2c_busy,
	input  wire logic              i2c_edge,
	// sensor side events
	input  wire logic              low_supply_pin,
	input  wire logic              wake_event,
	input  wire logic              data_ready,
	// outputs
	output logic [6:0]             target_address_bits,
	output logic [7:0]             status_out,
	output logic                   soft_reset
);
	// ==========================================
	// declarations
	logic       command_error_flag_ff;
	logic       low_supply_flag_ff;
	logic       setup_idle_flag_ff;
	logic       conversion_pending_flag_ff;
	logic [7:0] target_address_setting_ff;
	logic [2:0] busy_cnt_ff;
	logic [1:0] rst_cnt_ff;
	logic       low_s1_ff;
	logic       low_s2_ff;
	logic       stat_pending_ff;
	logic       uart_to;
	logic       i2c_to;
	logic       timeout;
	logic       soft_rst_now;
	logic [7:0] nxt_status;
	logic [7:0] write_data_ff;

	// ==========================================
	// supply monitor comes from analog domain, so synchronise it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_s1_ff <= 1'b0;
			low_s2_ff <= 1'b0;
		end else begin
			low_s1_ff <= low_supply_pin;
			low_s2_ff <= low_s1_ff;
		end
	end

	// ==========================================
	// idle timers, one per link
	sscf_idle_timer #(.LIMIT(IDLE_LIMIT)) u_uart_to (
		.clk      (clk),
		.rst_b    (rst_b),
		.busy     (uart_busy),
		.activity (uart_edge),
		.expired  (uart_to)
	);
	sscf_idle_timer #(.LIMIT(IDLE_LIMIT)) u_i2c_to (
		.clk      (clk),
		.rst_b    (rst_b),
		.busy     (i2c_busy),
		.activity (i2c_edge),
		.expired  (i2c_to)
	);
	assign timeout = uart_to | i2c_to; // RULE11

	// soft reset is triggered by reset command or restore command
	assign soft_rst_now = cmd.valid && !cmd.bad
		&& (cmd.code == sscf_pkg::CMD_RESET || cmd.code == sscf_pkg::CMD_RESTORE);

	// ==========================================
	// status byte as seen by the host; low nibble hard zero
	always_comb begin
		nxt_status = 8'h00; // RULE14
		nxt_status[sscf_pkg::STAT_ERR_BIT]  = command_error_flag_ff;
		nxt_status[sscf_pkg::STAT_LOW_BIT]  = low_supply_flag_ff;
		nxt_status[sscf_pkg::STAT_IDLE_BIT] = setup_idle_flag_ff;
		nxt_status[sscf_pkg::STAT_CONV_BIT] = conversion_pending_flag_ff;
	end

	// ==========================================
	// status read pending: remembers read until its byte is sent
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_pending_ff <= 1'b0;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RD_STATUS) begin
			stat_pending_ff <= 1'b1;
		end else if (rsp_sent) begin
			stat_pending_ff <= 1'b0;
		end
	end

	// ==========================================
	// error flag; a new event in the clear cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			command_error_flag_ff <= 1'b0;
		end else if ((cmd.valid && cmd.bad) || timeout) begin
			command_error_flag_ff <= 1'b1; // RULE1
		end else if (stat_pending_ff && rsp_sent) begin
			command_error_flag_ff <= 1'b0; // RULE15
		end
	end

	// ==========================================
	// low supply flag; level held low keeps it set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_supply_flag_ff <= 1'b0;
		end else if (low_s2_ff) begin
			low_supply_flag_ff <= 1'b1; // RULE2
		end else if (stat_pending_ff && rsp_sent) begin
			low_supply_flag_ff <= 1'b0; // RULE15
		end
	end

	// ==========================================
	// setup flag and write execution; the write takes a few cycles
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_idle_flag_ff <= 1'b1;
			busy_cnt_ff        <= 3'h0;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_WR_ADDR) begin
			setup_idle_flag_ff <= 1'b0; // RULE3
			busy_cnt_ff        <= 3'(sscf_pkg::WRITE_BUSY_CYC);
		end else if (busy_cnt_ff == 3'h1) begin
			setup_idle_flag_ff <= 1'b1; // RULE4
			busy_cnt_ff        <= 3'h0;
		end else if (busy_cnt_ff != 3'h0) begin
			busy_cnt_ff <= busy_cnt_ff - 3'h1;
		end
	end

	// ==========================================
	// address register; bit 0 forced zero so a careless host cannot break matching
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			target_address_setting_ff <= sscf_pkg::ADDR_FACTORY;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RESTORE) begin
			target_address_setting_ff <= sscf_pkg::ADDR_FACTORY; // RULE9
		end else if (busy_cnt_ff == 3'h1) begin
			target_address_setting_ff <= {write_data_ff[7:1], 1'b0}; // RULE8
		end
	end

	// ==========================================
	// write data waits here until the busy count lands it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			write_data_ff <= 8'h00;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_WR_ADDR) begin
			write_data_ff <= cmd.data;
		end
	end

	// match address output for the serial target
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			target_address_bits <= sscf_pkg::ADDR_FACTORY[7:1];
		end else begin
			target_address_bits <= target_address_setting_ff[7:sscf_pkg::ADDR_LSB]; // RULE7
		end
	end

	// ==========================================
	// software reset pulse two cycles after the command, so the reload settles first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_cnt_ff <= 2'h0;
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= 1'b0;
			if (soft_rst_now) begin
				rst_cnt_ff <= 2'(sscf_pkg::SWRST_CYC);
			end else if (rst_cnt_ff != 2'h0) begin
				rst_cnt_ff <= rst_cnt_ff - 2'h1;
				soft_reset <= (rst_cnt_ff == 2'h1); // RULE9
			end
		end
	end

	// ==========================================
	// conversion flag: reset starts a conversion, so set beats data ready
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conversion_pending_flag_ff <= 1'b1;
		end else if (soft_reset || wake_event) begin
			conversion_pending_flag_ff <= 1'b1; // RULE5
		end else if (data_ready) begin
			conversion_pending_flag_ff <= 1'b0; // RULE6
		end
	end

	// ==========================================
	// responses: answer only what the host asked; writes and setup stay silent
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rsp <= '0;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RD_STATUS) begin
			rsp.valid <= 1'b1; // RULE12
			rsp.data  <= nxt_status;
		end else if (cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RD_ADDR) begin
			rsp.valid <= 1'b1; // RULE10
			rsp.data  <= target_address_setting_ff;
		end else if (rsp_sent) begin
			rsp.valid <= 1'b0; // RULE13
		end
	end

	// registered copy of the status byte; lags the flags by one cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_out <= sscf_pkg::STAT_RESET;
		end else begin
			status_out <= nxt_status;
		end
	end

	// ==========================================
	// checks
	a_err_on_bad: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && cmd.bad) |=> command_error_flag_ff) // RULE1
		else $error("error flag not set after bad command");
	a_low_sets: assert property (@(posedge clk) disable iff (!rst_b)
		low_s2_ff |=> low_supply_flag_ff) // RULE2
		else $error("low flag missed");
	a_write_busy: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_WR_ADDR) |=> !setup_idle_flag_ff) // RULE3
		else $error("setup flag not busy");
	a_write_done: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(setup_idle_flag_ff) |-> ##[1:8] setup_idle_flag_ff) // RULE4
		else $error("setup flag stuck busy");
	a_conv_reset: assert property (@(posedge clk) disable iff (!rst_b)
		(soft_reset || wake_event) |=> conversion_pending_flag_ff) // RULE5
		else $error("conversion flag not set");
	a_conv_done: assert property (@(posedge clk) disable iff (!rst_b)
		(data_ready && !soft_reset && !wake_event) |=> !conversion_pending_flag_ff) // RULE6
		else $error("conversion flag not cleared");
	a_addr_match: assert property (@(posedge clk) disable iff (!rst_b)
		##1 target_address_bits == $past(target_address_setting_ff[7:1])) // RULE7
		else $error("match address wrong");
	a_restore_rst: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RESTORE)
		|=> target_address_setting_ff == sscf_pkg::ADDR_FACTORY ##2 soft_reset) // RULE9
		else $error("restore sequence wrong");
	a_timeout_err: assert property (@(posedge clk) disable iff (!rst_b)
		timeout |=> command_error_flag_ff) // RULE11
		else $error("time-out not flagged");
	a_stat_rsp: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RD_STATUS)
		|=> rsp.valid && rsp.data == $past(nxt_status)) // RULE12
		else $error("status response wrong");
	a_low_nibble: assert property (@(posedge clk) disable iff (!rst_b)
		status_out[3:0] == 4'h0) // RULE14
		else $error("status low bits not zero");
	a_clear_late: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(command_error_flag_ff)) |-> $past(stat_pending_ff && rsp_sent)) // RULE15
		else $error("error flag cleared early");
	a_low_clear_late: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(low_supply_flag_ff) |-> $past(stat_pending_ff && rsp_sent)) // RULE15
		else $error("low flag cleared early");
	a_err_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(command_error_flag_ff && !(stat_pending_ff && rsp_sent)) |=> command_error_flag_ff) // RULE1
		else $error("error flag lost before status read");
	a_low_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(low_supply_flag_ff && !(stat_pending_ff && rsp_sent)) |=> low_supply_flag_ff) // RULE2
		else $error("low flag lost before status read");
	a_restore_silent: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && !cmd.bad && cmd.code == sscf_pkg::CMD_RESTORE && !rsp.valid) |=> !rsp.valid) // RULE13
		else $error("restore produced a response");
	a_bad_silent: assert property (@(posedge clk) disable iff (!rst_b)
		(cmd.valid && cmd.bad && !rsp.valid) |=> !rsp.valid) // RULE10
		else $error("bad command produced a response");
	a_rsp_holds: assert property (@(posedge clk) disable iff (!rst_b)
		(rsp.valid && !rsp_sent && !cmd.valid) |=> rsp.valid && $stable(rsp.data)) // RULE12
		else $error("response byte dropped before sent");
	a_soft_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		soft_reset |=> !soft_reset) // RULE9
		else $error("software reset longer than one cycle");
endmodule
`default_nettype wire

// ### testbench/sscf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// framer side: takes each response byte after lag cycles
module sscf_host_model (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// response handshake
	input  wire sscf_pkg::sscf_rsp_t rsp,
	input  wire logic [3:0]          lag,
	output logic                     rsp_sent
);
	logic [3:0] wait_ff;
	logic       done_ff;

	// one sent pulse per byte; done_ff stops a second pulse while valid falls
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_ff  <= 4'h0;
			done_ff  <= 1'b0;
			rsp_sent <= 1'b0;
		end else if (rsp_sent) begin
			rsp_sent <= 1'b0;
			done_ff  <= 1'b1;
		end else if (rsp.valid && !done_ff) begin
			rsp_sent <= (wait_ff == lag);
			wait_ff  <= (wait_ff == lag) ? 4'h0 : wait_ff + 4'h1;
		end else if (!rsp.valid) begin
			done_ff <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### testbench/sensor_status_and_address_config_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) compares++; if ((a) !== (b)) begin n_errors++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end
module sensor_status_and_address_config_test;
	logic clk, rst_b, rsp_sent, uart_busy, i2c_busy, low_supply_pin, wake_event, data_ready, soft_reset;
	logic link_edge;
	logic [3:0] lag;
	logic [6:0] target_address_bits;
	logic [7:0] status_out, d;
	sscf_pkg::sscf_cmd_t cmd;
	sscf_pkg::sscf_rsp_t rsp;
	int n_errors, compares, cycles, n_rsp, n_soft;

	// ==========================================
	// design and framer model
	sscf_status_addr #(.IDLE_LIMIT(50)) dut (.clk(clk), .rst_b(rst_b), .cmd(cmd), .rsp_sent(rsp_sent),
		.rsp(rsp), .uart_busy(uart_busy), .uart_edge(link_edge), .i2c_busy(i2c_busy), .i2c_edge(link_edge),
		.low_supply_pin(low_supply_pin), .wake_event(wake_event), .data_ready(data_ready),
		.target_address_bits(target_address_bits), .status_out(status_out), .soft_reset(soft_reset));
	sscf_host_model host (.clk(clk), .rst_b(rst_b), .rsp(rsp), .lag(lag), .rsp_sent(rsp_sent));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// count response cycles and reset pulses; a hang ends the run
	always @(posedge clk) begin
		cycles++;
		if (rsp.valid === 1'b1) n_rsp++;
		if (soft_reset === 1'b1) n_soft++;
		if (cycles > 5000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic send(input logic [7:0] code, input logic [7:0] data, input logic bad);
		cmd = '{1'b1, code, data, bad};
		tick(1);
		cmd.valid = 1'b0;
	endtask

	// request a one-byte answer and hold it until the framer has sent it
	task automatic rd(input logic [7:0] code, output logic [7:0] data);
		int i;
		data = 8'hFF;
		send(code, 8'h00, 1'b0);
		for (i = 0; i < 20 && rsp.valid !== 1'b1; i++) tick(1);
		data = rsp.data;
		for (i = 0; i < 20 && rsp.valid !== 1'b0; i++) tick(1);
		tick(3);
	endtask

	task automatic pulse(input int which);
		if (which == 0) wake_event = 1'b1; else data_ready = 1'b1;
		tick(1);
		wake_event = 1'b0;
		data_ready = 1'b0;
		tick(3);
	endtask

	initial begin
		{rst_b, uart_busy, i2c_busy, low_supply_pin, wake_event, data_ready, link_edge} = '0;
		cmd = '0;
		lag = 4'h0;
		repeat (4) @(posedge clk);
		#1 rst_b = 1'b1;
		tick(2);
		`CHK(status_out, 8'h30)
		`CHK(target_address_bits, 7'h50)
		pulse(1);
		`CHK(status_out, 8'h20)
		$display("test reset done");
		// bad command, then status read with a slow framer
		lag = 4'h5;
		send(8'h0A, 8'h00, 1'b1);
		tick(2);
		`CHK(status_out, 8'hA0)
		rd(sscf_pkg::CMD_RD_STATUS, d);
		`CHK(d, 8'hA0)
		`CHK(status_out, 8'h20)
		lag = 4'h0;
		low_supply_pin = 1'b1;
		tick(5);
		low_supply_pin = 1'b0;
		tick(3);
		rd(sscf_pkg::CMD_RD_STATUS, d);
		`CHK(d, 8'h60)
		`CHK(status_out, 8'h20)
		$display("test flags done");
		// a link left busy with no activity on each link in turn
		for (int k = 0; k < 2; k++) begin
			if (k == 0) uart_busy = 1'b1; else i2c_busy = 1'b1;
			tick(60);
			{uart_busy, i2c_busy} = 2'b00;
			rd(sscf_pkg::CMD_RD_STATUS, d);
			`CHK(d, 8'hA0)
		end
		// link activity every 31 cycles keeps both idle timers from expiring
		{uart_busy, i2c_busy} = 2'b11;
		repeat (3) begin
			tick(30);
			link_edge = 1'b1;
			tick(1);
			link_edge = 1'b0;
		end
		{uart_busy, i2c_busy} = 2'b00;
		rd(sscf_pkg::CMD_RD_STATUS, d);
		`CHK(d, 8'h20)
		$display("test time-out done");
		// host keeps bit 0 of the address clear
		send(sscf_pkg::CMD_WR_ADDR, 8'h32, 1'b0);
		tick(1);
		`CHK(status_out[5], 1'b0)
		tick(5);
		`CHK(status_out[5], 1'b1)
		`CHK(target_address_bits, 7'h19)
		rd(sscf_pkg::CMD_RD_ADDR, d);
		`CHK(d, 8'h32)
		$display("test address done");
		n_soft = 0;
		send(sscf_pkg::CMD_RESET, 8'h00, 1'b0);
		tick(6);
		`CHK(status_out[4], 1'b1)
		`CHK(target_address_bits, 7'h19)
		pulse(1);
		`CHK(status_out[4], 1'b0)
		pulse(0);
		`CHK(status_out[4], 1'b1)
		n_rsp = 0;
		send(sscf_pkg::CMD_RESTORE, 8'h00, 1'b0);
		tick(6);
		`CHK(target_address_bits, 7'h50)
		`CHK(n_soft, 2)
		`CHK(n_rsp, 0)
		$display("test restore done");
		conclude();
	end
endmodule
`default_nettype wire
